// >>> design/cipu_edge.sv
// package of shared constants and the external request edge detector
// assumes one system clock; request pins are asynchronous to it
package cipu_pkg;
  localparam int unsigned ENTRY_CLKS = 10;
  localparam int unsigned RETI_CLKS = 7;
  localparam int unsigned INSTR_MAX_CLKS = 19;
  localparam int unsigned LATENCY_MAX_CLKS = 30;
  localparam int unsigned PRI_W = 2;
  localparam int unsigned STACK_W = 8;
  localparam int unsigned OP_W = 4;
  localparam logic [STACK_W-1:0] IP_RESET = 8'h00;
  localparam logic [STACK_W-1:0] VB_RESET = 8'h00;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [OP_W-1:0] OP_OTHER = 4'h0;
  localparam logic [OP_W-1:0] OP_LD_SP_PAIR = 4'h1;
  localparam logic [OP_W-1:0] OP_LD_SP_IDX1 = 4'h2;
  localparam logic [OP_W-1:0] OP_LD_SP_IDX2 = 4'h3;
  localparam logic [OP_W-1:0] OP_PRI_PUSH = 4'h4;
  localparam logic [OP_W-1:0] OP_PRI_RESTORE = 4'h5;
  localparam logic [OP_W-1:0] OP_PRI_POP = 4'h6;
  localparam logic [OP_W-1:0] OP_RETI = 4'h7;
  localparam logic [OP_W-1:0] OP_RD_PAGE = 4'h8;
  localparam logic [OP_W-1:0] OP_WR_PAGE = 4'h9;
  localparam logic [OP_W-1:0] OP_BIT_MEM = 4'hA;
  localparam logic [OP_W-1:0] OP_SET_MEM = 4'hB;
  localparam logic [OP_W-1:0] OP_RST = 4'hC;
  localparam logic [OP_W-1:0] OP_WR_IVB = 4'hD;
  localparam logic [OP_W-1:0] OP_WR_EVB = 4'hE;
  localparam logic [7:0] EXT0_VEC_LO = 8'h00;
  localparam logic [7:0] EXT1_VEC_LO = 8'h10;
  localparam logic [7:0] INT_VEC_BASE = 8'h00;
  localparam logic [7:0] INT_VEC_STEP = 8'h10;

  function automatic logic cipu_is_priv(input logic [OP_W-1:0] op);
    case (op)
      OP_LD_SP_PAIR, OP_LD_SP_IDX1, OP_LD_SP_IDX2, OP_PRI_PUSH, OP_PRI_RESTORE,
      OP_PRI_POP, OP_RETI, OP_RD_PAGE, OP_WR_PAGE, OP_BIT_MEM: cipu_is_priv = 1'b1;
      default: cipu_is_priv = 1'b0;
    endcase
  endfunction
endpackage

module cipu_edge (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input wire logic [1:0] edge_sel_i,
  output logic level_o,
  output logic edge_o
);
  import cipu_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } cipu_edge_t;
  cipu_edge_t r_r, r_nxt;

  // s1 feeds only s2; s3 is the delayed copy for edge compare
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = pin_i;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r_r <= '0;
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  assign level_o = r_r.s2;
  // a steady level never fires, only the chosen transition
  assign edge_o = (edge_sel_i[0] & r_r.s2 & ~r_r.s3) | (edge_sel_i[1] & ~r_r.s2 & r_r.s3);
endmodule // cipu_edge

// >>> design/cipu_top.sv
// processor-side interrupt acceptance: priority stack, deferral, vectoring
// assumes the core reports each completed instruction with its class and operand
// Behaviour
// - exactly two external request inputs
// - external requests raised by edges, never levels; internal requests are levels
// - edge select rising, falling or both
// - request pin level always readable
// - one transition gives exactly one interrupt
// - accept at instruction end, deferred after privileged
// - stack pointer loads are privileged
// - push shifts stack left, loads operand
// - restore rotates stack right two bits
// - return and pop load stack from memory
// - page access and memory bit test privileged
// - memory bit set keeps flags
// - four entries, deeper pushes lose oldest
// - routine starts within 30 clocks
// - return from interrupt takes 7 clocks
// - 8-bit stack, low two bits current
// - accept shifts left, loads accepted priority
// - accept only strictly higher priority; restarts unmasked
// - vector high from base, low fixed per source; restart low from operand
module cipu_top #(
  parameter int unsigned NINT = 4
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic [1:0] EXT_IRQ_I,
  input wire logic [3:0] EDGE_SEL_I,
  input wire logic [3:0] EXT_PRI_I,
  input wire logic [NINT-1:0] INT_REQ_I,
  input wire logic [2*NINT-1:0] INT_PRI_I,
  input wire logic INSTR_DONE_I,
  input wire logic [cipu_pkg::OP_W-1:0] INSTR_OP_I,
  input wire logic [7:0] INSTR_ARG_I,
  input wire logic [7:0] MEM_DATA_I,
  output logic [cipu_pkg::STACK_W-1:0] PRIORITY_STACK_O,
  output logic [7:0] IVB_O,
  output logic [7:0] EVB_O,
  output logic [1:0] EXT_LEVEL_O,
  output logic [1:0] EXT_PEND_O,
  output logic [NINT-1:0] INT_ACK_O,
  output logic ENTRY_BUSY_O,
  output logic ISR_START_O,
  output logic [15:0] VEC_ADDR_O,
  output logic RETI_BUSY_O,
  output logic RETI_DONE_O,
  output logic DEFER_O,
  output logic FLAGS_KEEP_O
);
  import cipu_pkg::*;

  // refused while elaborating: index and vector arithmetic only serve 1..15 sources
  if (NINT < 1 || NINT > 15) begin : g_nint_bad
    $error("NINT out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ENTRY = 3'b010,
    ST_RETI = 3'b100
  } cipu_state_t;

  typedef struct packed {
    cipu_state_t st;
    logic [STACK_W-1:0] ip;
    logic [7:0] ivb;
    logic [7:0] evb;
    logic [1:0] pend;
    logic [1:0] lvl;
    logic [3:0] cnt;
    logic [15:0] vec;
    logic [NINT-1:0] ack;
    logic isr_start;
    logic reti_done;
    logic defer;
    logic flags_keep;
  } cipu_regs_t;

  localparam logic [3:0] ENTRY_LOAD = 4'(ENTRY_CLKS - 1);
  localparam logic [3:0] RETI_LOAD = 4'(RETI_CLKS - 1);
  localparam logic [3:0] ENTRY_SEEN_LAST = 4'(ENTRY_CLKS - 1);

  cipu_regs_t r_r, r_nxt;
  logic [1:0] lvl_w, edge_w;
  logic [1:0] ext_clr;
  logic accept_w, rst_w, done_w;
  logic [PRI_W-1:0] best_pri;
  logic [7:0] best_lo;
  logic best_ext;
  int best_idx;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ext
      cipu_edge u_edge (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .ce_i(CE_I),
        .pin_i(EXT_IRQ_I[gi]),
        .edge_sel_i(EDGE_SEL_I[2*gi +: 2]),
        .level_o(lvl_w[gi]),
        .edge_o(edge_w[gi])
      );
    end
  endgenerate

  // pick the highest requester strictly above the current priority; ties go to lower index
  always_comb begin
    best_pri = r_r.ip[PRI_W-1:0];
    best_lo = EXT0_VEC_LO;
    best_ext = 1'b1;
    best_idx = -1;
    if (r_r.pend[0] && EXT_PRI_I[1:0] > best_pri) begin
      best_pri = EXT_PRI_I[1:0];
      best_idx = 0;
    end
    if (r_r.pend[1] && EXT_PRI_I[3:2] > best_pri) begin
      best_pri = EXT_PRI_I[3:2];
      best_lo = EXT1_VEC_LO;
      best_idx = 1;
    end
    for (int i = 0; i < NINT; i++) begin
      if (INT_REQ_I[i] && INT_PRI_I[2*i +: 2] > best_pri) begin
        best_pri = INT_PRI_I[2*i +: 2];
        best_lo = INT_VEC_BASE + 8'(i) * INT_VEC_STEP;
        best_ext = 1'b0;
        best_idx = i + 2;
      end
    end
  end

  assign done_w = INSTR_DONE_I && (r_r.st == ST_IDLE);
  assign rst_w = done_w && (INSTR_OP_I == OP_RST);
  // privileged completions never open the acceptance window
  assign accept_w = done_w && !cipu_is_priv(INSTR_OP_I) && !rst_w && (best_idx >= 0);

  always_comb begin
    r_nxt = r_r;
    r_nxt.isr_start = 1'b0;
    r_nxt.reti_done = 1'b0;
    r_nxt.ack = '0;
    r_nxt.lvl = lvl_w;
    ext_clr = 2'b00;
    if (INSTR_DONE_I) begin
      r_nxt.defer = cipu_is_priv(INSTR_OP_I);
      r_nxt.flags_keep = (INSTR_OP_I == OP_SET_MEM);
    end
    case (r_r.st)
      ST_IDLE: begin
        if (accept_w) begin
          r_nxt.ip = {r_r.ip[STACK_W-PRI_W-1:0], best_pri};
          r_nxt.vec = {best_ext ? r_r.evb : r_r.ivb, best_lo};
          if (best_idx < 2) begin
            ext_clr[best_idx[0]] = 1'b1;
          end else begin
            r_nxt.ack[best_idx-2] = 1'b1;
          end
          r_nxt.cnt = ENTRY_LOAD;
          r_nxt.st = ST_ENTRY;
        end else if (rst_w) begin
          // restarts ignore the processor priority and leave the stack alone
          r_nxt.vec = {r_r.ivb, INSTR_ARG_I};
          r_nxt.cnt = ENTRY_LOAD;
          r_nxt.st = ST_ENTRY;
        end else if (done_w) begin
          case (INSTR_OP_I)
            OP_PRI_PUSH: r_nxt.ip = {r_r.ip[STACK_W-PRI_W-1:0], INSTR_ARG_I[PRI_W-1:0]};
            OP_PRI_RESTORE: r_nxt.ip = {r_r.ip[PRI_W-1:0], r_r.ip[STACK_W-1:PRI_W]};
            OP_PRI_POP: r_nxt.ip = MEM_DATA_I;
            OP_RETI: begin
              r_nxt.ip = MEM_DATA_I;
              r_nxt.cnt = RETI_LOAD;
              r_nxt.st = ST_RETI;
            end
            OP_WR_IVB: r_nxt.ivb = INSTR_ARG_I;
            OP_WR_EVB: r_nxt.evb = INSTR_ARG_I;
            default: r_nxt.ip = r_r.ip;
          endcase
        end
      end
      ST_ENTRY: begin
        // fixed entry length keeps worst-case latency at 19 + 10 + 1 clocks
        if (r_r.cnt == '0) begin
          r_nxt.isr_start = 1'b1;
          r_nxt.st = ST_IDLE;
        end else begin
          r_nxt.cnt = r_r.cnt - 4'd1;
        end
      end
      ST_RETI: begin
        if (r_r.cnt == '0) begin
          r_nxt.reti_done = 1'b1;
          r_nxt.st = ST_IDLE;
        end else begin
          r_nxt.cnt = r_r.cnt - 4'd1;
        end
      end
      default: r_nxt.st = ST_IDLE;
    endcase
    // a new edge beats a clear in the same cycle; a shared line still makes one pending bit
    r_nxt.pend = (r_r.pend & ~ext_clr) | edge_w;
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      r_r <= '{st: ST_IDLE, ip: IP_RESET, ivb: VB_RESET, evb: VB_RESET, default: '0};
    end else if (CE_I) begin
      r_r <= r_nxt;
    end
  end

  assign PRIORITY_STACK_O = r_r.ip;
  assign IVB_O = r_r.ivb;
  assign EVB_O = r_r.evb;
  assign EXT_LEVEL_O = r_r.lvl;
  assign EXT_PEND_O = r_r.pend;
  assign INT_ACK_O = r_r.ack;
  assign ENTRY_BUSY_O = (r_r.st == ST_ENTRY);
  assign RETI_BUSY_O = (r_r.st == ST_RETI);
  assign ISR_START_O = r_r.isr_start;
  assign VEC_ADDR_O = r_r.vec;
  assign RETI_DONE_O = r_r.reti_done;
  assign DEFER_O = r_r.defer;
  assign FLAGS_KEEP_O = r_r.flags_keep;

  // check-only helper: enabled clocks already spent in entry, so the length check needs no long repetition
  logic [3:0] entry_seen_r;
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      entry_seen_r <= 4'h0;
    end else if (CE_I) begin
      entry_seen_r <= ENTRY_BUSY_O ? entry_seen_r + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  AST_PUSH: assert property (CE_I && done_w && INSTR_OP_I == OP_PRI_PUSH |=>
    PRIORITY_STACK_O == {$past(PRIORITY_STACK_O[5:0]), $past(INSTR_ARG_I[1:0])})
    else $error("push did not shift in operand");
  AST_RESTORE: assert property (CE_I && done_w && INSTR_OP_I == OP_PRI_RESTORE |=>
    PRIORITY_STACK_O == {$past(PRIORITY_STACK_O[1:0]), $past(PRIORITY_STACK_O[7:2])})
    else $error("restore did not rotate right by two");
  AST_POP: assert property (CE_I && done_w && (INSTR_OP_I == OP_PRI_POP || INSTR_OP_I == OP_RETI) |=>
    PRIORITY_STACK_O == $past(MEM_DATA_I))
    else $error("pop did not load memory byte");
  AST_ACCEPT: assert property (CE_I && accept_w |=> ENTRY_BUSY_O &&
    PRIORITY_STACK_O[7:2] == $past(PRIORITY_STACK_O[5:0]) && PRIORITY_STACK_O[1:0] > $past(PRIORITY_STACK_O[1:0]))
    else $error("accept did not stack a higher priority");
  AST_DEFER: assert property (CE_I && INSTR_DONE_I && cipu_is_priv(INSTR_OP_I) |=>
    !$rose(ENTRY_BUSY_O) && DEFER_O)
    else $error("interrupt taken after privileged instruction");
  AST_ENTRY_LEN: assert property (CE_I && ENTRY_BUSY_O && entry_seen_r == ENTRY_SEEN_LAST |=>
    ISR_START_O && !ENTRY_BUSY_O)
    else $error("entry did not end after ten clocks");
  AST_ENTRY_HOLD: assert property (CE_I && ENTRY_BUSY_O && entry_seen_r < ENTRY_SEEN_LAST |=>
    ENTRY_BUSY_O && !ISR_START_O)
    else $error("entry ended before ten clocks");
  AST_RETI_LEN: assert property ($rose(RETI_BUSY_O) && CE_I ##1 CE_I[*6] |=> RETI_DONE_O && !RETI_BUSY_O)
    else $error("return did not take seven clocks");
  AST_PEND_HOLD: assert property (CE_I && EXT_PEND_O[0] && !(accept_w && best_idx == 0) |=> EXT_PEND_O[0])
    else $error("pending edge lost before acceptance");
  AST_FLAGS: assert property (CE_I && INSTR_DONE_I && INSTR_OP_I == OP_SET_MEM |=> FLAGS_KEEP_O)
    else $error("flags not held on memory bit set");

  COV_ACCEPT: cover property (accept_w ##[1:12] ISR_START_O);
  COV_RST: cover property (CE_I && rst_w);
  COV_RETI: cover property ($rose(RETI_BUSY_O) ##[7:8] RETI_DONE_O);
  COV_DEFER: cover property (INSTR_DONE_I && cipu_is_priv(INSTR_OP_I) && EXT_PEND_O != 2'b00);
endmodule // cipu_top

// >>> verif/cipu_irq_devices.sv
// far-side model: four external devices sharing the two request pins
// assumes the bench drives each device request on a rising clock edge
module cipu_irq_devices (
  input wire logic [3:0] src_i,
  output logic [1:0] pin_o,
  output logic [3:0] attn_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // two devices or'ed per pin, so simultaneous requests make a single edge
  assign pin_o = {|src_i[3:2], |src_i[1:0]};
  // per-device lines let a dispatcher find every requester behind one edge
  assign attn_o = src_i;
endmodule // cipu_irq_devices

// >>> verif/cipu_top_tb.sv
// self-checking bench for the interrupt acceptance block
// assumes cipu_irq_devices drives the request pins; clock enable dropped once to check the freeze
module cipu_top_tb import cipu_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rstn = 1'b0, done = 1'b0, ce = 1'b1;
  logic [3:0] op = 4'h0, sel = 4'h0, epri = 4'h0, ireq = 4'h0, src = 4'h0, attn, ack;
  logic [7:0] arg = 8'h00, mem = 8'h00, ipri = 8'h00, stk, ivb, evb;
  logic [1:0] pin, lvl, pend;
  logic eb, isr, rb, rd, dfr, fk;
  logic [15:0] vec;
  int fail_count = 0, check_count = 0;
  logic [7:0] pp [5] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h01};
  logic [3:0] ops [8] = '{OP_LD_SP_PAIR, OP_LD_SP_IDX1, OP_LD_SP_IDX2, OP_RD_PAGE, OP_WR_PAGE,
    OP_BIT_MEM, OP_OTHER, OP_SET_MEM};
  initial forever #2 clk = ~clk;
  cipu_irq_devices dev (.src_i(src), .pin_o(pin), .attn_o(attn));
  cipu_top #(.NINT(4)) uut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .EXT_IRQ_I(pin), .EDGE_SEL_I(sel),
    .EXT_PRI_I(epri), .INT_REQ_I(ireq), .INT_PRI_I(ipri), .INSTR_DONE_I(done), .INSTR_OP_I(op),
    .INSTR_ARG_I(arg), .MEM_DATA_I(mem), .PRIORITY_STACK_O(stk), .IVB_O(ivb), .EVB_O(evb),
    .EXT_LEVEL_O(lvl), .EXT_PEND_O(pend), .INT_ACK_O(ack), .ENTRY_BUSY_O(eb), .ISR_START_O(isr),
    .VEC_ADDR_O(vec), .RETI_BUSY_O(rb), .RETI_DONE_O(rd), .DEFER_O(dfr), .FLAGS_KEEP_O(fk));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one completed instruction; returns in the cycle after it was taken
  task automatic ins(input logic [3:0] o, input logic [7:0] a, input logic [7:0] m);
    @(posedge clk);
    done <= 1'b1;
    op <= o;
    arg <= a;
    mem <= m;
    @(posedge clk);
    done <= 1'b0;
    #1;
  endtask
  task automatic entry(input logic [15:0] v);
    chk(vec, v);
    repeat (10) begin
      chk(eb, 1'b1);
      step(1);
    end
    chk({eb, isr}, 2'b01);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // the sequence needs well under 1000 cycles
  initial begin
    #20000;
    fail_count++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    step(1);
    chk({stk, ivb}, 16'h0000);
    chk({evb, 6'h00, pend}, 16'h0000);
    ins(OP_WR_EVB, 8'h40, 8'h00);
    ins(OP_WR_IVB, 8'h80, 8'h00);
    chk({evb, ivb}, 16'h4080);
    foreach (pp[i]) ins(OP_PRI_PUSH, pp[i], 8'h00);
    chk(stk, 8'hB1);
    chk(dfr, 1'b1);
    ins(OP_PRI_RESTORE, 8'h00, 8'h00);
    chk(stk, 8'h6C);
    ins(OP_PRI_POP, 8'h00, 8'h5A);
    chk(stk, 8'h5A);
    ins(OP_PRI_POP, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ins(ops[i], 8'h00, 8'h00);
      chk({dfr, fk}, {i < 6, ops[i] == OP_SET_MEM});
    end
    $display("test stack ops done");
    @(posedge clk);
    sel <= {EDGE_FALL, EDGE_RISE};
    epri <= 4'hA;
    src <= 4'h3;
    step(5);
    chk({lvl, pend}, 4'b0101);
    chk(attn, 4'h3);
    ins(OP_RD_PAGE, 8'h00, 8'h00);
    chk(eb, 1'b0);
    ins(OP_OTHER, 8'h00, 8'h00);
    chk({stk, 6'h00, pend}, 16'h0200);
    entry(16'h4000);
    step(5);
    chk(pend, 2'b00);
    @(posedge clk);
    src <= 4'hC;
    step(5);
    chk({lvl, pend}, 4'b1000);
    @(posedge clk);
    src <= 4'h0;
    step(5);
    chk(pend, 2'b10);
    ins(OP_OTHER, 8'h00, 8'h00);
    chk(eb, 1'b0);
    ins(OP_RETI, 8'h00, 8'h00);
    chk({stk, 7'h00, rb}, 16'h0001);
    repeat (6) begin
      step(1);
      chk(rb, 1'b1);
    end
    step(1);
    chk({rb, rd}, 2'b01);
    ins(OP_OTHER, 8'h00, 8'h00);
    chk({stk, 6'h00, pend}, 16'h0200);
    entry(16'h4010);
    $display("test external edges done");
    @(posedge clk);
    sel <= {EDGE_FALL, EDGE_BOTH};
    src <= 4'h1;
    step(5);
    chk(pend, 2'b01);
    ins(OP_RST, 8'h20, 8'h00);
    chk(stk, 8'h02);
    entry(16'h8020);
    @(posedge clk);
    ipri <= 8'h0C;
    ireq <= 4'h2;
    ins(OP_OTHER, 8'h00, 8'h00);
    chk({ack, 4'h0, stk}, 16'h200B);
    entry(16'h8010);
    @(posedge clk);
    ireq <= 4'h0;
    ce <= 1'b0;
    // a push completed while the enable is low must leave the stack frozen
    ins(OP_PRI_PUSH, 8'h01, 8'h00);
    chk(stk, 8'h0B);
    @(posedge clk);
    ce <= 1'b1;
    step(1);
    chk({stk, 7'h00, eb}, 16'h0B00);
    $display("test restart and internal done");
    conclude;
  end
endmodule // cipu_top_tb
